// file: common/pscint_pkg.sv
// Package holding the register map and field layout of the status change interrupt block
package pscint_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int unsigned  ADDR_W        = 5;           // Management register address width
    localparam int unsigned  DATA_W        = 16;          // Management register data width
    localparam logic [4:0]   ADDR_IRQ_EN   = 5'h12;       // interrupt_enable
    localparam logic [4:0]   ADDR_STS_CHG  = 5'h13;       // status_change_flags

    // ****************************************
    // Field layout
    // ****************************************
    localparam int unsigned  NUM_EVT       = 4;           // Event count
    localparam int unsigned  FIELD_LSB     = 4;           // Fields sit in bits 7:4
    localparam int unsigned  FIELD_MSB     = 7;
    localparam int unsigned  BIT_AUTONEG   = 3;           // Index in vector, register bit 7
    localparam int unsigned  BIT_SPEED     = 2;           // Register bit 6
    localparam int unsigned  BIT_DUPLEX    = 1;           // Register bit 5
    localparam int unsigned  BIT_LINK      = 0;           // Register bit 4

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [3:0]   RST_IRQ_EN    = 4'h0;        // All enables off
    localparam logic [3:0]   RST_FLAGS     = 4'h0;        // No change pending
    localparam logic [15:0]  RST_RDATA     = 16'h0000;    // Read data idle value
    localparam logic [3:0]   RISE_ONLY     = 4'h8;        // Autoneg flags on completion only

endpackage

// file: rtl/pscint_change_det.sv
// Change detector that turns status levels into one-cycle event pulses
module pscint_change_det
    import pscint_pkg::*;
#(
    parameter int unsigned  WIDTH     = NUM_EVT,          // Number of status levels
    parameter logic [3:0]   RISE_MASK = RISE_ONLY         // 1: rising edge only, 0: any change
) (
    input  wire logic              i_clock,               // Management clock
    input  wire logic              i_nrst,                // Async reset, active low
    input  wire logic [WIDTH-1:0]  i_level,               // Status levels, same clock domain
    output logic      [WIDTH-1:0]  o_pulse                // One-cycle change pulses
);

    // ****************************************
    // State
    // ****************************************
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] prev_d;
    logic             armed_q;
    logic             armed_d;

    // Capture the first level after reset without flagging it as a change
    always_comb begin
        prev_d  = i_level;
        armed_d = 1'b1;
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            prev_q  <= '0;
            armed_q <= 1'b0;
        end else begin
            prev_q  <= prev_d;
            armed_q <= armed_d;
        end
    end

    // One comparator per level; combinational so the pulse is seen the cycle it happens
    for (genvar g = 0; g < WIDTH; g++) begin : g_det
        if (RISE_MASK[g]) begin : g_rise
            assign o_pulse[g] = armed_q & i_level[g] & ~prev_q[g];
        end else begin : g_any
            assign o_pulse[g] = armed_q & (i_level[g] ^ prev_q[g]);
        end
    end

endmodule // pscint_change_det

// file: rtl/pscint_top.sv
// Status change flags, interrupt enables and interrupt output of the transceiver
module pscint_top
    import pscint_pkg::*;
(
    input  wire logic               i_clock,           // Management clock, 25 MHz
    input  wire logic               i_nrst,            // Async reset, active low
    input  wire logic [ADDR_W-1:0]  i_reg_addr,        // Register address
    input  wire logic               i_reg_wr,          // Write strobe, one cycle
    input  wire logic               i_reg_rd,          // Read strobe, one cycle
    input  wire logic [DATA_W-1:0]  i_reg_wdata,       // Write data
    output logic      [DATA_W-1:0]  o_reg_rdata,       // Read data, valid cycle after strobe
    input  wire logic               i_autoneg_done,    // Autoneg complete level
    input  wire logic               i_speed_100,       // Speed level
    input  wire logic               i_full_duplex,     // Duplex level
    input  wire logic               i_link_up,         // Link level
    output logic                    o_irq              // Interrupt, active high
);

    // ****************************************
    // Event detection
    // ****************************************
    logic [NUM_EVT-1:0] evt_pulse;

    pscint_change_det #(
        .WIDTH     (NUM_EVT),
        .RISE_MASK (RISE_ONLY)
    ) u_det (
        .i_clock (i_clock),
        .i_nrst  (i_nrst),
        .i_level ({i_autoneg_done, i_speed_100, i_full_duplex, i_link_up}),
        .o_pulse (evt_pulse)
    );

    // ****************************************
    // Registers
    // ****************************************
    logic [NUM_EVT-1:0] irq_en_q;
    logic [NUM_EVT-1:0] irq_en_d;
    logic [NUM_EVT-1:0] flags_q;
    logic [NUM_EVT-1:0] flags_d;
    logic [DATA_W-1:0]  rdata_q;
    logic [DATA_W-1:0]  rdata_d;
    logic               irq_q;
    logic               irq_d;
    logic               rd_sts;
    logic               wr_en;

    assign rd_sts = i_reg_rd & (i_reg_addr == ADDR_STS_CHG);
    assign wr_en  = i_reg_wr & (i_reg_addr == ADDR_IRQ_EN);

    // Next register values; only the four enable bits are stored, others drop
    always_comb begin
        irq_en_d = irq_en_q;
        if (wr_en) begin
            irq_en_d = i_reg_wdata[FIELD_MSB:FIELD_LSB];
        end
        // Read clears, a pulse in the same cycle wins so no change is lost
        flags_d = (rd_sts ? RST_FLAGS : flags_q) | evt_pulse;
        // Writes to the status address are simply not decoded
        rdata_d = RST_RDATA;
        if (i_reg_rd && (i_reg_addr == ADDR_IRQ_EN)) begin
            rdata_d[FIELD_MSB:FIELD_LSB] = irq_en_q;
        end else if (rd_sts) begin
            rdata_d[FIELD_MSB:FIELD_LSB] = flags_q;
        end
        // Registered output costs a cycle but keeps the pin glitch-free
        irq_d = |(flags_q & irq_en_q);
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_en_q <= RST_IRQ_EN;
            flags_q  <= RST_FLAGS;
            rdata_q  <= RST_RDATA;
            irq_q    <= 1'b0;
        end else begin
            irq_en_q <= irq_en_d;
            flags_q  <= flags_d;
            rdata_q  <= rdata_d;
            irq_q    <= irq_d;
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_irq       = irq_q;

    // ****************************************
    // Named fields
    // ****************************************
    // One name per enable and flag bit, so the checks below read like the register map
    logic autoneg_done_irq_enable;
    logic speed_change_irq_enable;
    logic duplex_change_irq_enable;
    logic link_change_irq_enable;
    logic autoneg_finished_flag;
    logic speed_changed_flag;
    logic duplex_changed_flag;
    logic link_changed_flag;

    // Enable fields, bits 7:4 of interrupt_enable
    assign autoneg_done_irq_enable  = irq_en_q[BIT_AUTONEG];   // Bit 7
    assign speed_change_irq_enable  = irq_en_q[BIT_SPEED];     // Bit 6
    assign duplex_change_irq_enable = irq_en_q[BIT_DUPLEX];    // Bit 5
    assign link_change_irq_enable   = irq_en_q[BIT_LINK];      // Bit 4

    // Flag fields, bits 7:4 of status_change_flags
    assign autoneg_finished_flag    = flags_q[BIT_AUTONEG];    // Bit 7
    assign speed_changed_flag       = flags_q[BIT_SPEED];      // Bit 6
    assign duplex_changed_flag      = flags_q[BIT_DUPLEX];     // Bit 5
    assign link_changed_flag        = flags_q[BIT_LINK];       // Bit 4

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    // Status read with no event in the same cycle, so no flag may outlive it
    sequence s_read_quiet;
        rd_sts && (evt_pulse == '0);
    endsequence

    // Flags empty one cycle after the read, interrupt gone one cycle after that
    sequence s_flags_clear;
        (flags_q == '0) ##1 !o_irq;
    endsequence

    // Status read that meets a fresh event in the same cycle
    sequence s_read_busy;
        rd_sts && (evt_pulse != '0);
    endsequence

    // Read strobe aimed at the enable register
    sequence s_enable_read;
        i_reg_rd && (i_reg_addr == ADDR_IRQ_EN);
    endsequence

    // Read strobe aimed at neither register
    sequence s_unmapped_read;
        i_reg_rd && (i_reg_addr != ADDR_IRQ_EN) && (i_reg_addr != ADDR_STS_CHG);
    endsequence

    // Write aimed at the read-only status register while no read or event moves it
    sequence s_status_write;
        i_reg_wr && (i_reg_addr == ADDR_STS_CHG) && !rd_sts && (evt_pulse == '0);
    endsequence

    // ****************************************
    // Interrupt gating
    // ****************************************
    // Each latched and enabled flag reaches the pin one cycle later, through the output flop
    an_gate_a: assert property (autoneg_finished_flag && autoneg_done_irq_enable
        |=> o_irq)
        else $error("autoneg flag enabled but no interrupt");
    speed_gate_a: assert property (speed_changed_flag && speed_change_irq_enable
        |=> o_irq)
        else $error("speed flag enabled but no interrupt");
    duplex_gate_a: assert property (duplex_changed_flag && duplex_change_irq_enable
        |=> o_irq)
        else $error("duplex flag enabled but no interrupt");
    link_gate_a: assert property (link_changed_flag && link_change_irq_enable
        |=> o_irq)
        else $error("link flag enabled but no interrupt");
    // A masked flag must never reach the pin, or software polling would see spurious calls
    mask_block_a: assert property ((flags_q & irq_en_q) == '0 |=> !o_irq)
        else $error("masked flags raised the interrupt");

    // ****************************************
    // Flag latching
    // ****************************************
    // Completion of autoneg is latched on the next edge
    an_latch_a: assert property (evt_pulse[BIT_AUTONEG] |=> autoneg_finished_flag)
        else $error("autoneg completion not latched");
    // Autoneg dropping back is not an event, only its completion is
    an_fall_a: assert property ($fell(i_autoneg_done) |-> !evt_pulse[BIT_AUTONEG])
        else $error("autoneg drop raised an event");
    // Level changes count only once the detector has been armed after reset
    change_latch_a: assert property ($changed(i_speed_100) && $past(i_nrst)
        |=> speed_changed_flag)
        else $error("speed change not latched");
    duplex_latch_a: assert property ($changed(i_full_duplex) && $past(i_nrst)
        |=> duplex_changed_flag)
        else $error("duplex change not latched");
    link_latch_a: assert property ($changed(i_link_up) && $past(i_nrst)
        |=> link_changed_flag)
        else $error("link change not latched");
    // A flag only rises from an event of the cycle before, never by itself
    flag_cause_a: assert property (1'b1 |=>
        (flags_q & ~$past(flags_q) & ~$past(evt_pulse)) == '0)
        else $error("flag set without a change event");
    // Without a status read a set flag stays set
    flag_hold_a: assert property (!rd_sts
        |=> (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("flag lost without a status read");
    // An event in the cycle of a clearing read is kept, older flags are not
    set_wins_a: assert property (s_read_busy |=> flags_q == $past(evt_pulse))
        else $error("event lost in the cycle of a status read");
    read_clear_a: assert property (s_read_quiet |=> s_flags_clear)
        else $error("status read did not clear flags and interrupt");
    // The status register is read-only, so a write must not touch the flags
    status_wr_a: assert property (s_status_write |=> $stable(flags_q))
        else $error("status write changed the flags");

    // ****************************************
    // Register reads and writes
    // ****************************************
    read_data_a: assert property (rd_sts |=> o_reg_rdata == {8'h00, $past(flags_q), 4'h0})
        else $error("status read data wrong or reserved bits set");
    en_read_a: assert property (s_enable_read
        |=> o_reg_rdata == {8'h00, $past(irq_en_q), 4'h0})
        else $error("enable read data wrong or reserved bits set");
    en_write_a: assert property (wr_en
        |=> {8'h00, irq_en_q, 4'h0} == ($past(i_reg_wdata) & 16'h00f0))
        else $error("enable write not stored");
    en_hold_a: assert property (!wr_en |=> $stable(irq_en_q))
        else $error("enable changed without a write");
    // Read data is zero outside read cycles, so a stale word is never mistaken for a new one
    rdata_idle_a: assert property (!i_reg_rd |=> o_reg_rdata == '0)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (s_unmapped_read |=> o_reg_rdata == '0)
        else $error("unmapped read returned nonzero data");

endmodule // pscint_top

// file: tb/pscint_host.sv
// Host management controller model driving the register strobes
module pscint_host (
    input  wire logic         i_clock,   // Management clock
    input  wire logic [15:0]  i_rdata,   // Read data from device
    output logic      [4:0]   o_addr,    // Register address
    output logic              o_wr,      // Write strobe
    output logic              o_rd,      // Read strobe
    output logic      [15:0]  o_wdata    // Write data
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus at time zero
    initial begin
        o_addr  = 5'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_wdata = 16'h0000;
    end
    // One write pulse; released lines invert so stale values are never trusted
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge i_clock);
        o_addr  <= a;
        o_wdata <= v & 16'h00f0; // Unused positions written as zero
        o_wr    <= 1'b1;
        @(posedge i_clock);
        o_wr    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~v;
    endtask
    // One read pulse; data taken on the falling edge after the edge that samples the strobe
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge i_clock);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clock);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        @(negedge i_clock);
        v = i_rdata;
    endtask
endmodule // pscint_host

// file: tb/tb_phy_status_change_interrupt.sv
// Self-checking bench of the status change interrupt block
module tb_phy_status_change_interrupt;
    timeunit 1ns;
    timeprecision 1ns;
    import pscint_pkg::*;
    logic        i_clock = 1'b0;
    logic        i_nrst  = 1'b0;
    logic [3:0]  lvl     = 4'h0;
    logic [4:0]  addr;
    logic        wr, rd, irq;
    logic [15:0] wdata, rdata, d;
    logic [3:0]  en, flg, nl;
    logic [31:0] seed = 32'h4b60;
    int          errors = 0, tests_run = 0;
    always #20 i_clock = ~i_clock;
    // Device and host model
    pscint_top dut_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_autoneg_done(lvl[3]),
        .i_speed_100(lvl[2]), .i_full_duplex(lvl[1]), .i_link_up(lvl[0]), .o_irq(irq));
    pscint_host host_u (.i_clock(i_clock), .i_rdata(rdata), .o_addr(addr), .o_wr(wr),
        .o_rd(rd), .o_wdata(wdata));
    // Xorshift source, fixed start for repeatable runs
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Autoneg flags only on completion, others on any change
    function automatic logic [3:0] evts(input logic [3:0] o, input logic [3:0] n);
        return (o ^ n) & {~o[3], 3'b111};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict();
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge i_clock);
        i_nrst <= 1'b1;
        host_u.rd(ADDR_IRQ_EN, d);
        chk("enable", 16'h0000, d);
        host_u.rd(ADDR_STS_CHG, d);
        chk("status", 16'h0000, d);
        host_u.wr(ADDR_STS_CHG, 16'h00f0);
        host_u.rd(ADDR_STS_CHG, d);
        chk("status", 16'h0000, d);
        host_u.rd(5'h1f, d);
        chk("unmapped", 16'h0000, d);
        for (int i = 0; i < 40; i++) begin
            en = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : 4'(rnd());
            host_u.wr(ADDR_IRQ_EN, {8'h00, en, 4'h0});
            host_u.rd(ADDR_IRQ_EN, d);
            chk("enable", {8'h00, en, 4'h0}, d);
            nl  = (i < 2) ? ~lvl : 4'(rnd());
            flg = evts(lvl, nl);
            @(posedge i_clock);
            lvl <= nl;
            repeat (2) @(posedge i_clock);
            @(negedge i_clock);
            chk("irq", {15'h0000, |(flg & en)}, {15'h0000, irq});
            host_u.rd(ADDR_STS_CHG, d);
            chk("status", {8'h00, flg, 4'h0}, d);
            @(negedge i_clock);
            chk("irq", 16'h0000, {15'h0000, irq});
            chk("rdata", 16'h0000, rdata);
            host_u.rd(ADDR_STS_CHG, d);
            chk("status", 16'h0000, d);
        end
        // Change arriving in the cycle of a clearing read must outlive that read
        nl  = ~lvl;
        flg = evts(lvl, nl);
        fork
            host_u.rd(ADDR_STS_CHG, d);
            begin
                @(posedge i_clock);
                lvl <= nl;
            end
        join
        chk("status", 16'h0000, d);
        host_u.rd(ADDR_STS_CHG, d);
        chk("status", {8'h00, flg, 4'h0}, d);
        // Mid-run reset with enables and flags set; levels held at release raise nothing
        host_u.wr(ADDR_IRQ_EN, 16'h00f0);
        @(posedge i_clock);
        lvl <= lvl ^ 4'h7;
        repeat (2) @(posedge i_clock);
        @(negedge i_clock);
        chk("irq", 16'h0001, {15'h0000, irq});
        @(posedge i_clock);
        i_nrst <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(negedge i_clock);
        chk("irq", 16'h0000, {15'h0000, irq});
        host_u.rd(ADDR_IRQ_EN, d);
        chk("enable", 16'h0000, d);
        host_u.rd(ADDR_STS_CHG, d);
        chk("status", 16'h0000, d);
        print_verdict();
    end
endmodule // tb_phy_status_change_interrupt
